// file: shared/pwr_mode_pkg.sv
// constants and types shared by the power mode controller
package pwr_mode_pkg;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ACT_TMPL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ALT_TMPL = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_WAKE_CAUSE = 4'h4;

    // mode register field
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;

    // encoded mode values as software sees them
    localparam logic [MODE_W-1:0] CODE_ACTIVE = 2'h0;
    localparam logic [MODE_W-1:0] CODE_ALT = 2'h1;
    localparam logic [MODE_W-1:0] CODE_SLEEP = 2'h2;
    localparam logic [MODE_W-1:0] CODE_HIBER = 2'h3;

    // status register fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_CPU_EN_BIT = 2;
    localparam int STAT_OVR_BIT = 3;

    // wake cause fields, write one to clear
    localparam int CAUSE_IRQ_BIT = 0;
    localparam int CAUSE_PIN_BIT = 1;

    // subsystem slots in the templates
    localparam int SUB_CPU = 0;
    localparam int SUB_FLASH = 1;
    localparam int SUB_TIMER = 2;

    // template values after reset, and the clock mask kept in sleep
    localparam logic [DATA_W-1:0] ACT_TMPL_RST = 8'hFF;
    localparam logic [DATA_W-1:0] ALT_TMPL_RST = 8'hFC;
    localparam logic [DATA_W-1:0] SLEEP_KEEP = 8'h04;

    typedef enum logic [3:0] {
        MODE_ACTIVE = 4'b0001,
        MODE_ALT = 4'b0010,
        MODE_SLEEP = 4'b0100,
        MODE_HIBER = 4'b1000
    } mode_e;

endpackage : pwr_mode_pkg

// file: core/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // asynchronous pin
    input wire logic pin,
    // filtered level and its rising edge
    output logic level,
    output logic rise
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic rise_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
                rise_q <= s3_q & ~level_q;
            end
        end
    end

    assign level = level_q;
    assign rise = rise_q;

endmodule : pin_sync

// file: core/power_mode_controller.sv
// global power mode controller with per-subsystem clock gating
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - four modes: active, alternate, sleep, hibernate
// - separate template register per active mode
// - active mode follows active template bits
// - disabled resource gets its clock gated
// - template writes take effect without mode change
// - cpu may disable itself, wakeup re-enables
// - wakeup forces active mode and cpu on
// - active is the mode after reset
// - alternate mode uses own template, cpu optional
// - sleep keeps only the timer clock
// - hibernate stops all clocks, pin wakes only
module power_mode_controller
    import pwr_mode_pkg::*;
#(
    parameter int NUM_SUB = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // wakeup sources
    input wire logic irq_wake,
    input wire logic sleep_wake,
    input wire logic io_wake_pin,
    // power control
    output logic [NUM_SUB-1:0] clk_en,
    output logic [MODE_W-1:0] mode,
    output logic cpu_en,
    output logic retain,
    output logic wake_pulse
);

    // timer slot must exist and every slot needs a template bit
    if (NUM_SUB < 3 || NUM_SUB > DATA_W) begin : g_bad_num_sub
        $error("NUM_SUB must lie between 3 and DATA_W");
    end


    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic [MODE_W-1:0] mode_code(input mode_e m);
        case (m)
            MODE_ACTIVE: mode_code = CODE_ACTIVE;
            MODE_ALT: mode_code = CODE_ALT;
            MODE_SLEEP: mode_code = CODE_SLEEP;
            MODE_HIBER: mode_code = CODE_HIBER;
            default: mode_code = CODE_ACTIVE;
        endcase
    endfunction : mode_code

    function automatic mode_e code_mode(input logic [MODE_W-1:0] c);
        case (c)
            CODE_ACTIVE: code_mode = MODE_ACTIVE;
            CODE_ALT: code_mode = MODE_ALT;
            CODE_SLEEP: code_mode = MODE_SLEEP;
            CODE_HIBER: code_mode = MODE_HIBER;
            default: code_mode = MODE_ACTIVE;
        endcase
    endfunction : code_mode

    ////////////////////////////////////////////////////////////////////////
    // register strobes

    logic wr_mode;
    logic wr_act;
    logic wr_alt;
    logic wr_cause;

    assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
    assign wr_act = reg_wr && (reg_addr == OFS_ACT_TMPL);
    assign wr_alt = reg_wr && (reg_addr == OFS_ALT_TMPL);
    assign wr_cause = reg_wr && (reg_addr == OFS_WAKE_CAUSE);

    ////////////////////////////////////////////////////////////////////////
    // wakeup qualification

    logic pin_level;
    logic pin_rise;

    pin_sync u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin(io_wake_pin),
        .level(pin_level),
        .rise(pin_rise)
    );

    mode_e mode_q;
    mode_e mode_d;
    logic irq_hit;
    logic wake;

    // in sleep only the sleep-capable sources count; in hibernate the
    // pin is the sole source since no other logic has a clock there
    always_comb begin
        irq_hit = 1'b0;
        case (mode_q)
            MODE_ACTIVE: irq_hit = irq_wake | pin_rise;
            MODE_ALT: irq_hit = irq_wake | pin_rise;
            MODE_SLEEP: irq_hit = sleep_wake | pin_rise;
            MODE_HIBER: irq_hit = pin_rise;
            default: irq_hit = 1'b0;
        endcase
    end

    assign wake = irq_hit;

    ////////////////////////////////////////////////////////////////////////
    // mode state machine

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_ACTIVE, MODE_ALT, MODE_SLEEP, MODE_HIBER: begin
                if (wake) begin
                    mode_d = MODE_ACTIVE;
                end else if (wr_mode) begin
                    mode_d = code_mode(reg_wdata[MODE_LSB +: MODE_W]);
                end
            end
            default: mode_d = MODE_ACTIVE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= MODE_ACTIVE;
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // templates

    logic [DATA_W-1:0] act_tmpl_q;
    logic [DATA_W-1:0] alt_tmpl_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_tmpl_q <= ACT_TMPL_RST;
        end else if (wr_act) begin
            act_tmpl_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_tmpl_q <= ALT_TMPL_RST;
        end else if (wr_alt) begin
            alt_tmpl_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu override after wakeup

    logic cpu_ovr_q;

    // holds the cpu on in active and alternate mode after a wakeup until firmware
    // rewrites either template, active or alternate; a wakeup in that same cycle still wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_ovr_q <= 1'b0;
        end else if (wake) begin
            cpu_ovr_q <= 1'b1;
        end else if (wr_act || wr_alt) begin
            cpu_ovr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake cause, sticky, write one to clear

    logic [1:0] cause_q;
    logic [1:0] cause_set;

    assign cause_set = {pin_rise & wake, wake & ~pin_rise};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cause_q <= 2'b00;
        end else begin
            cause_q <= cause_set |
                (cause_q & ~(wr_cause ? reg_wdata[1:0] : 2'b00));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-subsystem clock enables

    logic [NUM_SUB-1:0] en_d;
    logic [NUM_SUB-1:0] en_q;

    // enables follow the template of the next mode, so a mode change
    // and a template write both land on the very next edge
    generate
        for (genvar i = 0; i < NUM_SUB; i++) begin : g_sub
            always_comb begin
                en_d[i] = 1'b0;
                case (mode_d)
                    MODE_ACTIVE: en_d[i] =
                        (wr_act ? reg_wdata[i] : act_tmpl_q[i]);
                    MODE_ALT: en_d[i] =
                        (wr_alt ? reg_wdata[i] : alt_tmpl_q[i]);
                    MODE_SLEEP: en_d[i] = SLEEP_KEEP[i];
                    MODE_HIBER: en_d[i] = 1'b0;
                    default: en_d[i] = 1'b0;
                endcase
                if (i == SUB_CPU && (wake || (cpu_ovr_q && !wr_act
                        && !wr_alt)) && (mode_d == MODE_ACTIVE
                        || mode_d == MODE_ALT)) begin
                    en_d[i] = 1'b1;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    en_q[i] <= ACT_TMPL_RST[i];
                end else begin
                    en_q[i] <= en_d[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // mode outputs

    logic [MODE_W-1:0] mode_out_q;
    logic retain_q;
    logic wake_pulse_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_out_q <= CODE_ACTIVE;
            retain_q <= 1'b0;
            wake_pulse_q <= 1'b0;
        end else begin
            mode_out_q <= mode_code(mode_d);
            retain_q <= (mode_d == MODE_HIBER);
            wake_pulse_q <= wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data stand one cycle after the strobe only

    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] status;

    always_comb begin
        status = '0;
        status[STAT_MODE_LSB +: MODE_W] = mode_code(mode_q);
        status[STAT_CPU_EN_BIT] = en_q[SUB_CPU];
        status[STAT_OVR_BIT] = cpu_ovr_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_MODE: rdata_q <= {{(DATA_W-MODE_W){1'b0}},
                    mode_code(mode_q)};
                OFS_ACT_TMPL: rdata_q <= act_tmpl_q;
                OFS_ALT_TMPL: rdata_q <= alt_tmpl_q;
                OFS_STATUS: rdata_q <= status;
                OFS_WAKE_CAUSE: rdata_q <= {{(DATA_W-2){1'b0}}, cause_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign clk_en = en_q;
    assign mode = mode_out_q;
    assign cpu_en = en_q[SUB_CPU];
    assign retain = retain_q;
    assign wake_pulse = wake_pulse_q;

endmodule : power_mode_controller

// file: testbench/power_mode_controller_checker.sv
// port assertions for the power mode controller
`timescale 1ns/1ns
module power_mode_controller_checker
    import pwr_mode_pkg::*;
#(
    parameter int NUM_SUB = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // wakeup sources
    input wire logic irq_wake,
    input wire logic sleep_wake,
    input wire logic io_wake_pin,
    // power control
    input wire logic [NUM_SUB-1:0] clk_en,
    input wire logic [MODE_W-1:0] mode,
    input wire logic cpu_en,
    input wire logic retain,
    input wire logic wake_pulse
);
    logic [2:0] quiet_q;
    logic [NUM_SUB-1:0] wd_q;
    logic quiet;
    ////////////////////////////////////////
    // pin edge may still sit in the synchroniser for a few cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) quiet_q <= 3'h0;
        else if (io_wake_pin) quiet_q <= 3'h0;
        else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
    always_ff @(posedge clk) begin
        wd_q <= reg_wdata[NUM_SUB-1:0];
    end
    assign quiet = (quiet_q == 3'h7) && !irq_wake && !sleep_wake;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    property p_wake;
        (irq_wake && (mode == CODE_ACTIVE || mode == CODE_ALT))
            || (sleep_wake && mode == CODE_SLEEP)
            |=> wake_pulse && mode == CODE_ACTIVE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake not taken");
    property p_cpu_back;
        wake_pulse |-> cpu_en;
    endproperty
    a_cpu_back: assert property (p_cpu_back)
        else $error("cpu not enabled on wake");
    property p_cpu_tie;
        reg_wr && reg_addr == OFS_ACT_TMPL && quiet && mode == CODE_ACTIVE
            |=> cpu_en == wd_q[SUB_CPU];
    endproperty
    a_cpu_tie: assert property (p_cpu_tie)
        else $error("cpu enable does not follow its template bit");
    property p_sleep;
        mode == CODE_SLEEP |-> clk_en == SLEEP_KEEP[NUM_SUB-1:0];
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep clock enables wrong");
    property p_hiber;
        mode == CODE_HIBER |-> clk_en == '0 && retain;
    endproperty
    a_hiber: assert property (p_hiber)
        else $error("hibernate clocks or retain wrong");
    property p_hold;
        (mode == CODE_HIBER && quiet_q == 3'h7 && !reg_wr)[*3]
            |=> mode == CODE_HIBER;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hibernate left without pin");
    property p_mode_wr;
        reg_wr && reg_addr == OFS_MODE && quiet && mode != CODE_HIBER
            |=> mode == wd_q[MODE_W-1:0];
    endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("mode write not applied");
    property p_act_wr;
        reg_wr && reg_addr == OFS_ACT_TMPL && quiet && mode == CODE_ACTIVE
            |=> clk_en == wd_q;
    endproperty
    a_act_wr: assert property (p_act_wr)
        else $error("active template write not applied");
    property p_alt_wr;
        reg_wr && reg_addr == OFS_ALT_TMPL && quiet && mode == CODE_ALT
            |=> clk_en == wd_q;
    endproperty
    a_alt_wr: assert property (p_alt_wr)
        else $error("alternate template write not applied");
endmodule : power_mode_controller_checker
bind power_mode_controller power_mode_controller_checker #(
    .NUM_SUB(NUM_SUB)
) power_mode_controller_checker_i (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_wake(irq_wake), .sleep_wake(sleep_wake),
    .io_wake_pin(io_wake_pin), .clk_en(clk_en), .mode(mode),
    .cpu_en(cpu_en), .retain(retain), .wake_pulse(wake_pulse)
);

// file: testbench/testbench.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ns
module testbench
    import pwr_mode_pkg::*;
;
    logic clk, reset_n, reg_wr, reg_rd, irq_wake, sleep_wake, io_wake_pin;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, act, alt, rv;
    logic [7:0] clk_en;
    logic [MODE_W-1:0] mode, c;
    logic cpu_en, retain, wake_pulse, ovr;
    int n_errors = 0;
    int total_checks = 0;
    power_mode_controller #(.NUM_SUB(8)) power_mode_controller_i (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_wake(irq_wake), .sleep_wake(sleep_wake),
        .io_wake_pin(io_wake_pin), .clk_en(clk_en), .mode(mode),
        .cpu_en(cpu_en), .retain(retain), .wake_pulse(wake_pulse)
    );
    ////////////////////////////////////////
    // wake sets the cpu override, a template write clears it
    function automatic logic [7:0] exp_clk(input logic [1:0] m);
        case (m)
            CODE_ACTIVE: return act | {7'h00, ovr};
            CODE_ALT: return alt | {7'h00, ovr};
            CODE_SLEEP: return SLEEP_KEEP;
            default: return 8'h00;
        endcase
    endfunction : exp_clk
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic chkm(input logic [1:0] exp);
        chk({6'h00, mode}, {6'h00, exp});
    endtask : chkm
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic wake(input logic irq, input logic slp);
        @(posedge clk);
        irq_wake <= irq;
        sleep_wake <= slp;
        @(posedge clk);
        irq_wake <= 1'b0;
        sleep_wake <= 1'b0;
        #1;
    endtask : wake
    task automatic pin_wake();
        @(posedge clk);
        io_wake_pin <= 1'b1;
        for (int i = 0; i < 12 && wake_pulse !== 1'b1; i++) @(posedge clk) #1;
        chk({7'h00, wake_pulse}, 8'h01);
        chkm(CODE_ACTIVE);
        @(posedge clk);
        io_wake_pin <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : pin_wake
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        n_errors++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        irq_wake = 1'b0;
        sleep_wake = 1'b0;
        io_wake_pin = 1'b0;
        void'($urandom(74));
        act = ACT_TMPL_RST;
        alt = ALT_TMPL_RST;
        ovr = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chkm(CODE_ACTIVE);
        chk(clk_en, exp_clk(CODE_ACTIVE));
        rd(OFS_ALT_TMPL, rv);
        chk(rv, ALT_TMPL_RST);
        rd(4'hA, rv);
        chk(rv, 8'h00);
        $display("test reset done");
        // last value leaves the cpu gated so the wake must revive it
        for (int i = 0; i < 8; i++) begin
            act = (i == 0) ? 8'h00 : (i == 7) ? 8'hFE : 8'($urandom);
            wr(OFS_ACT_TMPL, act);
            ovr = 1'b0;
            chk(clk_en, exp_clk(CODE_ACTIVE));
            chk({7'h00, cpu_en}, {7'h00, act[SUB_CPU]});
        end
        wake(1'b1, 1'b0);
        ovr = 1'b1;
        chk({7'h00, wake_pulse}, 8'h01);
        chk(clk_en, exp_clk(CODE_ACTIVE));
        $display("test active done");
        for (int k = 1; k < 4; k++) begin
            c = 2'(k);
            alt = (k == 1) ? ALT_TMPL_RST : 8'($urandom);
            wr(OFS_ALT_TMPL, alt);
            ovr = 1'b0;
            wr(OFS_MODE, {6'h00, c});
            chkm(c);
            chk(clk_en, exp_clk(c));
            chk({7'h00, retain}, {7'h00, c == CODE_HIBER});
            if (c == CODE_ALT) begin
                alt = 8'($urandom);
                wr(OFS_ALT_TMPL, alt);
                chk(clk_en, exp_clk(c));
            end
            wake(1'b1, 1'b0);
            chkm((c == CODE_ALT) ? CODE_ACTIVE : c);
            wake(1'b0, 1'b1);
            chkm((c == CODE_HIBER) ? c : CODE_ACTIVE);
            pin_wake();
            ovr = 1'b1;
            chk(clk_en, exp_clk(CODE_ACTIVE));
            $display("test mode %0d done", k);
        end
        rd(OFS_ACT_TMPL, rv);
        chk(rv, act);
        rd(OFS_STATUS, rv);
        chk(rv, 8'h0C);
        rd(OFS_WAKE_CAUSE, rv);
        chk(rv, 8'h03);
        wr(OFS_WAKE_CAUSE, 8'h03);
        rd(OFS_WAKE_CAUSE, rv);
        chk(rv, 8'h00);
        wr(OFS_MODE, {6'h00, CODE_ALT});
        chkm(CODE_ALT);
        chk(clk_en, exp_clk(CODE_ALT));
        wr(OFS_MODE, {6'h00, CODE_ACTIVE});
        chkm(CODE_ACTIVE);
        chk(clk_en, exp_clk(CODE_ACTIVE));
        $display("test status done");
        finish_test();
    end
endmodule : testbench
